// >>> hdl/fetch_host_end.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Filter gives new samples every 1024 cycles
// - Filter raises ready when samples exist
// - Ready rising edge lowers chip select
// - First byte is read/write command
// - Command reads filter module one data
// - Send zero dummy byte per received byte
// - Filter streams next registers until deselect
// - Order: data, time, data, time, data
// - Host discards time bytes, keeps data
// - Filter drops ready after full readout
// - Chip select high after full response
// - Latch previous sets before fetching new
// - Trigger timer clears every 1024 cycles
// - Trigger edge converts three voltages sequentially
// - Completion event, re-enable before next trigger
module two_entry_buf
  import sample_fetch_pkg::*;
#(
  parameter int W = 96
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2]; // Storage entries
  logic wp_ff; // Write index
  logic rp_ff; // Read index
  logic [1:0] cnt_ff; // Occupancy
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rp_ff];

  // Pointer and occupancy update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (ce) begin
      if (push) begin
        mem_ff[wp_ff] <= in_data;
        wp_ff <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// Host sequencer: fetches current sets and drives voltage conversions
module fetch_host_end
  import sample_fetch_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Link
  filter_spi_if.host spi,
  // Fetched current set
  output logic cur_valid,
  input wire logic cur_ready,
  output logic [95:0] cur_data,
  // Latched older sets
  output logic [95:0] cur_hist_ff,
  output logic [47:0] volt_hist_ff,
  output logic latch_pulse_ff,
  // Voltage converter
  input wire logic [15:0] volt_in,
  output logic [1:0] volt_chan_ff,
  output logic conv_done_ff,
  input wire logic conv_rearm
);
  typedef enum logic [1:0] {IDLE, SEL, XFER, DONE} fetch_e;
  fetch_e st_ff;
  logic rdy_d_ff; // Previous ready level
  logic pend_ff; // Ready rise held while a push drains
  logic cs_n_ff; // Chip select
  logic sck_ff; // Serial clock
  logic mosi_ff; // Output data
  logic [3:0] div_ff; // Clock divider
  logic [7:0] tx_ff; // Transmit shifter
  logic [7:0] rx_ff; // Receive shifter
  logic [2:0] bit_ff; // Bit index
  logic [4:0] byte_ff; // Byte index, 0 is command
  logic [95:0] words_ff; // Kept data words
  logic [95:0] last_set_ff; // Previous fetched currents
  logic push_ff; // Buffer write request
  logic [10:0] tmr_ff; // Trigger timer
  logic trig_ff; // Trigger output level
  logic trig_d_ff; // Previous trigger level
  logic armed_ff; // Converter enabled
  logic busy_ff; // Conversion sequence running
  logic [3:0] conv_cnt_ff; // Cycles in current conversion
  logic [47:0] volt_ff; // Converted voltages
  logic buf_in_ready;
  wire rdy_rise = spi.sample_ready & ~rdy_d_ff;
  wire div_hit = (div_ff == SCK_HALF);
  wire byte_end = div_hit & sck_ff & (bit_ff == 3'h7);
  wire last_byte = (byte_ff == STREAM_BYTES);
  // Stream position: data bytes at 0-3, 6-9, 12-15
  wire [4:0] pos = byte_ff - 5'h01;
  wire is_time = (pos == 5'h04) | (pos == 5'h05) | (pos == 5'h0a) | (pos == 5'h0b);
  wire keep = (byte_ff != 5'h00) & ~is_time;
  wire trig_rise = trig_ff & ~trig_d_ff;
  wire conv_end = busy_ff & (conv_cnt_ff == CONV_CYCLES);
  assign spi.cs_n = cs_n_ff;
  assign spi.sck = sck_ff;
  assign spi.mosi = mosi_ff;

  // Hand fetched sets to the consumer without loss on stall
  two_entry_buf #(.W(96)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push_ff),
    .in_ready(buf_in_ready),
    .in_data(words_ff),
    .out_valid(cur_valid),
    .out_ready(cur_ready),
    .out_data(cur_data)
  );

  // Fetch sequencer and serial engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= IDLE;
      rdy_d_ff <= 1'b0;
      pend_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      div_ff <= '0;
      tx_ff <= SHIFT_RST;
      rx_ff <= SHIFT_RST;
      bit_ff <= '0;
      byte_ff <= '0;
      words_ff <= '0;
      last_set_ff <= '0;
      cur_hist_ff <= '0;
      volt_hist_ff <= '0;
      latch_pulse_ff <= 1'b0;
      push_ff <= 1'b0;
    end else if (ce) begin
      rdy_d_ff <= spi.sample_ready;
      pend_ff <= pend_ff | rdy_rise;
      latch_pulse_ff <= 1'b0;
      if (push_ff & buf_in_ready) begin
        push_ff <= 1'b0;
      end
      unique case (st_ff)
        IDLE: begin
          // Wait for a previous push to drain before starting
          if ((rdy_rise | pend_ff) & ~push_ff) begin
            // Keep older sets before the new fetch starts
            volt_hist_ff <= volt_ff;
            cur_hist_ff <= last_set_ff;
            latch_pulse_ff <= 1'b1;
            pend_ff <= 1'b0;
            st_ff <= SEL;
          end
        end
        SEL: begin
          // Select only once the older sets are latched
          cs_n_ff <= 1'b0;
          tx_ff <= {CMD_READ_DATA1[6:0], 1'b0};
          mosi_ff <= CMD_READ_DATA1[7];
          div_ff <= '0;
          bit_ff <= '0;
          byte_ff <= '0;
          st_ff <= XFER;
        end
        XFER: begin
          div_ff <= div_hit ? '0 : div_ff + 4'h1;
          if (div_hit) begin
            sck_ff <= ~sck_ff;
            if (!sck_ff) begin
              rx_ff <= {rx_ff[6:0], spi.miso};
            end else begin
              bit_ff <= bit_ff + 3'h1;
              mosi_ff <= tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          end
          if (byte_end) begin
            // Keep data bytes, drop time bytes
            if (keep) begin
              words_ff <= {words_ff[87:0], rx_ff};
            end
            byte_ff <= byte_ff + 5'h01;
            tx_ff <= DUMMY_BYTE;
            mosi_ff <= DUMMY_BYTE[7];
            if (last_byte) begin
              st_ff <= DONE;
            end
          end
        end
        DONE: begin
          cs_n_ff <= 1'b1;
          last_set_ff <= words_ff;
          push_ff <= 1'b1;
          st_ff <= IDLE;
        end
      endcase
    end
  end

  // Trigger timer, cleared once per sampling period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_ff <= '0;
      trig_ff <= 1'b0;
      trig_d_ff <= 1'b0;
    end else if (ce) begin
      tmr_ff <= (tmr_ff == OSR_LAST) ? '0 : tmr_ff + 11'h001;
      trig_ff <= (tmr_ff >= TRIG_POINT);
      trig_d_ff <= trig_ff;
    end
  end

  // Three-channel voltage conversion sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_ff <= 1'b1;
      busy_ff <= 1'b0;
      conv_cnt_ff <= '0;
      volt_chan_ff <= '0;
      volt_ff <= '0;
      conv_done_ff <= 1'b0;
    end else if (ce) begin
      conv_done_ff <= 1'b0;
      if (conv_rearm) begin
        armed_ff <= 1'b1;
      end
      if (trig_rise & armed_ff & ~busy_ff) begin
        busy_ff <= 1'b1;
        armed_ff <= 1'b0;
        volt_chan_ff <= 2'h0;
        conv_cnt_ff <= '0;
      end else if (busy_ff) begin
        conv_cnt_ff <= conv_end ? '0 : conv_cnt_ff + 4'h1;
        if (conv_end) begin
          // Store result, then move to the next channel
          volt_ff <= {volt_ff[31:0], volt_in};
          volt_chan_ff <= volt_chan_ff + 2'h1;
          if (volt_chan_ff == 2'h2) begin
            busy_ff <= 1'b0;
            conv_done_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/filter_device_end.sv
`timescale 1ns/10ps
`default_nettype none
// Filter device end: produces sample sets and streams registers
module filter_device_end
  import sample_fetch_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Sample inputs from the filter modules
  input wire logic [31:0] ch1_data,
  input wire logic [31:0] ch2_data,
  input wire logic [31:0] ch3_data,
  // Link
  filter_spi_if.filt spi
);
  logic [10:0] osr_cnt_ff; // Modulation period counter
  logic ready_ff; // Sample ready level
  logic [127:0] stream_ff; // Registers in address order
  logic [7:0] cmd_ff; // Received command bits
  logic [2:0] bit_ff; // Bit within byte
  logic [4:0] byte_ff; // Byte count in transaction
  logic sck_d_ff; // Previous serial clock
  logic miso_ff; // Output data bit
  logic streaming_ff; // Command matched, stream running
  wire sck_rise = spi.sck & ~sck_d_ff;
  wire sck_fall = ~spi.sck & sck_d_ff;
  wire period_end = (osr_cnt_ff == OSR_LAST);
  wire cmd_done = ~spi.cs_n & sck_rise & (bit_ff == 3'h7) & (byte_ff == 5'h00);
  wire cmd_ok = ({cmd_ff[6:0], spi.mosi} == CMD_READ_DATA1);
  wire last_bit = streaming_ff & sck_rise & (bit_ff == 3'h7) & (byte_ff == STREAM_BYTES);
  assign spi.sample_ready = ready_ff;
  assign spi.miso = miso_ff;

  // Period counter, ready flag and stream shifter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osr_cnt_ff <= '0;
      ready_ff <= 1'b0;
      stream_ff <= '0;
      cmd_ff <= SHIFT_RST;
      bit_ff <= '0;
      byte_ff <= '0;
      sck_d_ff <= 1'b0;
      miso_ff <= 1'b0;
      streaming_ff <= 1'b0;
    end else if (ce) begin
      sck_d_ff <= spi.sck;
      osr_cnt_ff <= period_end ? '0 : osr_cnt_ff + 11'h001;
      if (period_end) begin
        ready_ff <= 1'b1;
        // Data, time, data, time, data
        stream_ff <= {ch1_data, 16'h0000, ch2_data, 16'h0000, ch3_data};
      end else if (last_bit) begin
        ready_ff <= 1'b0;
      end
      if (spi.cs_n) begin
        bit_ff <= '0;
        byte_ff <= '0;
        streaming_ff <= 1'b0;
      end else if (sck_rise) begin
        // Sample MSB first on rising edge
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
          byte_ff <= byte_ff + 5'h01;
        end
        if (byte_ff == 5'h00) begin
          cmd_ff <= {cmd_ff[6:0], spi.mosi};
        end
        if (cmd_done) begin
          streaming_ff <= cmd_ok;
        end
      end else if (sck_fall & streaming_ff) begin
        // Keep shifting registers in order until deselect
        miso_ff <= stream_ff[127];
        stream_ff <= {stream_ff[126:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/filter_spi_if.sv
`timescale 1ns/10ps
`default_nettype none
// Serial link between acquisition host and filter device
interface filter_spi_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic sample_ready;
  modport host (output cs_n, output sck, output mosi, input miso, input sample_ready);
  modport filt (input cs_n, input sck, input mosi, output miso, output sample_ready);
endinterface
`default_nettype wire

// >>> hdl/sample_fetch_pkg.sv
package sample_fetch_pkg;
  // Modulation clock cycles per sample set
  localparam int unsigned OSR_CYCLES = 1024;
  localparam logic [10:0] OSR_LAST = 11'h3ff;
  // Read command addressing filter module 1 data
  localparam logic [7:0] CMD_READ_DATA1 = 8'h9d;
  // Dummy byte clocked for every received byte
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // Response stream layout in bytes
  localparam int unsigned DATA_BYTES = 4;
  localparam int unsigned TIME_BYTES = 2;
  localparam logic [4:0] STREAM_BYTES = 5'h10;
  // Serial clock divider: last divider count, half period is SCK_HALF+1 clk cycles
  localparam logic [3:0] SCK_HALF = 4'h2;
  // Trigger timer compare point within the period
  localparam logic [10:0] TRIG_POINT = 11'h010;
  // Last cycle count of a voltage conversion, which takes CONV_CYCLES+1 cycles
  localparam logic [3:0] CONV_CYCLES = 4'h8;
  // Reset values
  localparam logic [7:0] SHIFT_RST = 8'h00;
endpackage

// >>> test/fetch_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the serial link between the two ends
module fetch_link_checker
  import sample_fetch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sample_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Delayed copies for edge finding
  logic sck_ff;
  logic rdy_ff;
  // Serial clock rises in this frame
  logic [7:0] rise_cnt_ff;
  // Host bits, newest in bit 0
  logic [7:0] shift_ff;
  // Cycles since the last ready rise
  logic [10:0] gap_ff;
  // A first ready rise was seen
  logic seen_ff;
  wire sck_rise = sck && !sck_ff;
  wire rdy_rise = sample_ready && !rdy_ff;
  // Helper counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rise_cnt_ff <= 8'h00;
      shift_ff <= 8'h00;
      gap_ff <= 11'h000;
      seen_ff <= 1'b0;
    end else begin
      sck_ff <= sck;
      rdy_ff <= sample_ready;
      rise_cnt_ff <= cs_n ? 8'h00 : rise_cnt_ff + {7'h00, sck_rise};
      if (sck_rise) begin
        shift_ff <= {shift_ff[6:0], mosi};
      end
      gap_ff <= rdy_rise ? 11'h000 : gap_ff + 11'h001;
      seen_ff <= seen_ff | rdy_rise;
    end
  end
  a_ready_period: assert property (seen_ff && rdy_rise |-> gap_ff == OSR_LAST)
    else $error("ready spacing wrong");
  a_select_on_ready: assert property ($rose(sample_ready) |-> ##[1:4] !cs_n)
    else $error("no select after ready");
  a_command_first: assert property ($rose(rise_cnt_ff == 8'h08) |-> shift_ff == CMD_READ_DATA1)
    else $error("command byte wrong");
  a_dummy_zeros: assert property (!cs_n && sck_rise && rise_cnt_ff >= 8'h08 |-> !mosi)
    else $error("dummy bit not zero");
  a_frame_length: assert property ($rose(cs_n) |-> rise_cnt_ff == 8'h88)
    else $error("frame clock count wrong");
  a_ready_cleared: assert property ($rose(cs_n) |-> !sample_ready)
    else $error("ready still high");
  a_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("clock runs while idle");
  a_mosi_steady: assert property (sck && !cs_n |-> $stable(mosi))
    else $error("host bit moved");
  a_miso_steady: assert property (sck && !cs_n |-> $stable(miso))
    else $error("device bit moved");
  // Main scenarios
  c_frame: cover property ($rose(cs_n));
  c_period: cover property (seen_ff && rdy_rise);
  c_ready_drop: cover property ($fell(sample_ready));
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// Host and filter ends joined back to back
module testbench;
  // Stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cur_ready = 1'b0;
  logic conv_rearm = 1'b0;
  logic [15:0] volt_in = 16'h0a5c;
  logic [95:0] set_a = {32'h8123_4567, 32'h00fe_dcba, 32'h7f00_ff01};
  logic [95:0] set_b = {32'hdead_0001, 32'h0102_0304, 32'hffff_fffe};
  logic [95:0] set_c = {32'h5a5a_a5a5, 32'h8000_0000, 32'h0000_0001};
  logic [95:0] chs = set_a;
  // Host outputs
  logic cur_valid, latch_pulse_ff, conv_done_ff;
  logic [95:0] cur_data, cur_hist_ff;
  logic [47:0] volt_hist_ff;
  logic [1:0] volt_chan_ff;
  // Bookkeeping
  int err_count = 0, n_compared = 0, cyc = 0;
  int last_done = 0, n_done = 0, n_latch = 0, exp_gap = 1024;
  logic rearm_en = 1'b1;
  logic rearm_kick = 1'b0;
  // Link and channel levels, frozen while the enable is low
  wire [6:0] link_now = {spi_bus.cs_n, spi_bus.sck, spi_bus.mosi, spi_bus.miso,
    spi_bus.sample_ready, volt_chan_ff};
  logic [6:0] snap;
  always #50 clk = ~clk;
  filter_spi_if spi_bus();
  filter_device_end filter_device_end_inst(.clk(clk), .rst_n(rst_n), .ce(ce),
    .ch1_data(chs[95:64]), .ch2_data(chs[63:32]), .ch3_data(chs[31:0]), .spi(spi_bus.filt));
  fetch_host_end fetch_host_end_inst(.clk(clk), .rst_n(rst_n), .ce(ce), .spi(spi_bus.host),
    .cur_valid(cur_valid), .cur_ready(cur_ready), .cur_data(cur_data),
    .cur_hist_ff(cur_hist_ff), .volt_hist_ff(volt_hist_ff), .latch_pulse_ff(latch_pulse_ff),
    .volt_in(volt_in), .volt_chan_ff(volt_chan_ff), .conv_done_ff(conv_done_ff),
    .conv_rearm(conv_rearm));
  fetch_link_checker fetch_link_checker_inst(.clk(clk), .rst_n(rst_n), .cs_n(spi_bus.cs_n),
    .sck(spi_bus.sck), .mosi(spi_bus.mosi), .miso(spi_bus.miso),
    .sample_ready(spi_bus.sample_ready));
  // Compare and count
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Wait for a select level, bounded
  task automatic wait_cs(input logic lvl);
    int i;
    for (i = 0; i < 2000 && spi_bus.cs_n !== lvl; i++) @(negedge clk);
    check(96'(spi_bus.cs_n), 96'(lvl));
  endtask
  // Take one set from the buffer
  task automatic pop_set(input logic [95:0] exp);
    int i;
    @(negedge clk);
    for (i = 0; i < 3000 && cur_valid !== 1'b1; i++) @(negedge clk);
    check(96'(cur_valid), 96'h1);
    check(cur_data, exp);
    @(posedge clk);
    cur_ready <= 1'b1;
    @(posedge clk);
    cur_ready <= 1'b0;
  endtask
  // Wait for the next conversion end, bounded
  task automatic wait_done;
    int n0;
    int i;
    n0 = n_done;
    for (i = 0; i < 2500 && n_done == n0; i++) @(posedge clk);
    check(96'(n_done - n0), 96'h1);
  endtask
  // Cycle count and rearm pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    conv_rearm <= (conv_done_ff & rearm_en) | rearm_kick;
    // Each channel shows its own level so the store order is visible
    volt_in <= 16'h0a5c + {14'h0, volt_chan_ff};
  end
  // Conversion spacing and latched history
  always @(negedge clk) begin
    if (conv_done_ff === 1'b1) begin
      if (last_done != 0) check(96'(cyc - last_done), 96'(exp_gap));
      check(96'(volt_chan_ff), 96'h3);
      last_done = cyc;
      n_done++;
    end
    if (latch_pulse_ff === 1'b1) begin
      n_latch++;
      if (n_latch == 2) begin
        check(cur_hist_ff, set_a);
        check({48'h0, volt_hist_ff}, {48'h0, 16'h0a5c, 16'h0a5d, 16'h0a5e});
        check({95'h0, spi_bus.cs_n}, 96'h1);
      end
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_cs(1'b0);
    @(posedge clk);
    chs <= set_b;
    wait_cs(1'b1);
    wait_cs(1'b0);
    wait_cs(1'b1);
    @(posedge clk);
    chs <= set_c;
    pop_set(set_a);
    pop_set(set_b);
    pop_set(set_c);
    rearm_en <= 1'b0;
    wait_done();
    exp_gap = 2048;
    repeat (1300) @(posedge clk);
    rearm_kick <= 1'b1;
    @(posedge clk);
    rearm_kick <= 1'b0;
    wait_done();
    // Freeze both ends mid-frame; nothing on the link may move
    ce <= 1'b0;
    @(negedge clk);
    snap = link_now;
    repeat (20) @(negedge clk);
    check(96'(link_now), 96'(snap));
    @(posedge clk);
    ce <= 1'b1;
    tally_and_finish();
  end
  // Watchdog
  initial begin
    repeat (12000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
